/* File: rtl/spi_sleep_pkg.sv */
// constants for the serial select and sleep control block
package spi_sleep_pkg;
  // system clock rate
  localparam int SYS_CLK_HZ = 20000000;
  // wake and sleep delays, in nanoseconds as printed (20 us)
  localparam int WAKE_TIME_NS = 20000;
  localparam int SLEEP_TIME_NS = 20000;
  // cycle counts, typical delays rounded down
  localparam int WAKE_CYCLES = (WAKE_TIME_NS / 1000) * (SYS_CLK_HZ / 1000000);
  localparam int SLEEP_CYCLES = (SLEEP_TIME_NS / 1000) * (SYS_CLK_HZ / 1000000);
  localparam int CNT_W = 10;
  // transmit byte width and reset value
  localparam int BYTE_W = 8;
  localparam logic [7:0] TX_RESET = 8'h00;
  localparam logic [9:0] CNT_RESET = 10'h000;
endpackage

/* File: rtl/spi_select_sleep_control.sv */
// select-driven sleep control and serial slave output for a reader host port
`timescale 1ns/1ps
module spi_select_sleep_control
  import spi_sleep_pkg::*;
(
  // system side
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic tagBusy,
  input wire logic txLoadValid,
  input wire logic [7:0] txLoadData,
  output logic txLoadReady,
  output logic sleeping,
  output logic awake,
  output logic progMode,
  // link pins
  input wire logic spiClk,
  input wire logic selectN,
  output logic misoOut,
  output logic misoOe
);
  // ==========================================================
  // select synchroniser into the system domain
  // three stages: the pin is asynchronous to sys_clk, and the extra stage
  // lets the stable copy move only once two samples agree
  // reset value is deselected so the port starts out eligible to sleep
  logic sel1_q, sel2_q, sel3_q, selStable_q;
  logic selStable_d;
  // change accepted once second and third stages agree
  always_comb begin
    selStable_d = (sel2_q == sel3_q) ? sel3_q : selStable_q;
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sel1_q <= 1'b1;
      sel2_q <= 1'b1;
      sel3_q <= 1'b1;
      selStable_q <= 1'b1;
    end else begin
      sel1_q <= selectN;
      sel2_q <= sel1_q;
      sel3_q <= sel2_q;
      selStable_q <= selStable_d;
    end
  end

  // ==========================================================
  // power state machine
  // active -> to_sleep -> sleep -> waking -> active; one shared counter
  // times both the sleep delay and the wake delay, they never overlap
  // the typical delays are taken as exact counts, which a user timing
  // against a worst case must allow for
  typedef enum logic [1:0] {ST_ACTIVE, ST_TO_SLEEP, ST_SLEEP, ST_WAKING} pwr_e;
  pwr_e pwr_q, pwr_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  always_comb begin
    pwr_d = pwr_q;
    cnt_d = cnt_q;
    case (pwr_q)
      // waiting for select high and no tag work
      ST_ACTIVE: begin
        cnt_d = CNT_RESET;
        if (selStable_q && !tagBusy) begin
          pwr_d = ST_TO_SLEEP;
        end
      end
      // any select or busy event abandons the countdown
      ST_TO_SLEEP: begin
        if (!selStable_q || tagBusy) begin
          pwr_d = ST_ACTIVE;
          cnt_d = CNT_RESET;
        end else if (cnt_q == CNT_W'(SLEEP_CYCLES - 1)) begin
          pwr_d = ST_SLEEP;
          cnt_d = CNT_RESET;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      // only a stable low select leaves sleep
      ST_SLEEP: begin
        cnt_d = CNT_RESET;
        if (!selStable_q) begin
          pwr_d = ST_WAKING;
        end
      end
      ST_WAKING: begin
        // wake always runs to completion so the clock settles
        if (cnt_q == CNT_W'(WAKE_CYCLES - 1)) begin
          pwr_d = ST_ACTIVE;
          cnt_d = CNT_RESET;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        pwr_d = ST_ACTIVE;
        cnt_d = CNT_RESET;
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pwr_q <= ST_ACTIVE;
      cnt_q <= CNT_RESET;
    end else begin
      pwr_q <= pwr_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // mode outputs
  // programming mode is a registered copy of the reset level, so it has
  // no reset of its own and follows the input one edge late
  logic prog_q;
  always_ff @(posedge sys_clk) begin
    prog_q <= !resetn;
  end
  assign progMode = prog_q;
  assign sleeping = (pwr_q == ST_SLEEP);
  assign awake = (pwr_q == ST_ACTIVE) || (pwr_q == ST_TO_SLEEP);

  // ==========================================================
  // transmit buffer, loaded only while deselected
  // ready needs both the stable copy and the last stage high, so a falling
  // select closes the load window a cycle before the stable copy follows
  // limitation: loads can still land in the first few cycles after select
  // falls; the host's wake wait covers that window
  logic [7:0] txBuf_q, txBuf_d;
  assign txLoadReady = selStable_q && sel3_q && resetn;
  always_comb begin
    txBuf_d = txBuf_q;
    if (txLoadValid && txLoadReady) begin
      txBuf_d = txLoadData;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      txBuf_q <= TX_RESET;
    end else begin
      txBuf_q <= txBuf_d;
    end
  end

  // ==========================================================
  // link side shifter; buffer is quiet while the stable select copy is low so no crossing glitch
  // the shifter runs on the link clock and reads the buffer directly; the
  // buffer is held still from the fourth sys_clk edge after select falls, so no word crosses while it moves
  logic [2:0] bitIdx_q, bitIdx_d;
  always_comb begin
    bitIdx_d = bitIdx_q + 3'h1;
  end
  // select high acts as the frame's own reset for the bit index
  always_ff @(negedge spiClk or posedge selectN) begin
    if (selectN) begin
      bitIdx_q <= 3'h0;
    end else begin
      bitIdx_q <= bitIdx_d;
    end
  end
  logic [2:0] outIdx;
  assign outIdx = 3'h7 - bitIdx_q;
  assign misoOut = txBuf_q[outIdx];
  // released whenever deselected, and while programming
  assign misoOe = !selectN && resetn;

  // ==========================================================
  // observers for the checks; they feed no function logic
  // each run counter saturates so a long quiet spell never wraps to zero
  logic [CNT_W:0] idleRun_q, idleRun_d;
  logic [CNT_W:0] wakeRun_q, wakeRun_d;
  logic [CNT_W:0] selRun_q, selRun_d;
  // cycles with select high and no tag work
  always_comb begin
    idleRun_d = idleRun_q;
    if (!selStable_q || tagBusy) begin
      idleRun_d = '0;
    end else if (!(&idleRun_q)) begin
      idleRun_d = idleRun_q + 1'b1;
    end
  end
  // cycles spent in the waking state
  always_comb begin
    wakeRun_d = wakeRun_q;
    if (pwr_q != ST_WAKING) begin
      wakeRun_d = '0;
    end else if (!(&wakeRun_q)) begin
      wakeRun_d = wakeRun_q + 1'b1;
    end
  end
  // cycles with the stable select copy low
  always_comb begin
    selRun_d = selRun_q;
    if (selStable_q) begin
      selRun_d = '0;
    end else if (!(&selRun_q)) begin
      selRun_d = selRun_q + 1'b1;
    end
  end
  // observers clear with the rest of the block
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      idleRun_q <= '0;
      wakeRun_q <= '0;
      selRun_q <= '0;
    end else begin
      idleRun_q <= idleRun_d;
      wakeRun_q <= wakeRun_d;
      selRun_q <= selRun_d;
    end
  end

  // ==========================================================
  // checks
  // every check is clocked by sys_clk; the four on data out and programming mode run
  // through reset, the rest are disabled while it is held
  // sleep entry decided only with select high and no tag work
  a_sleep_needs_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pwr_q == ST_TO_SLEEP && pwr_d == ST_SLEEP) |-> (selStable_q && !tagBusy))
    else $error("sleep entered while selected or busy");
  // the sleep countdown holds off sleep for at least a few cycles
  a_sleep_delay: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(pwr_q == ST_TO_SLEEP) |-> !sleeping [*8])
    else $error("sleep entered too soon");
  // a stable low select in sleep starts the wake at the next edge
  a_wake_start: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sleeping && !selStable_q) |=> (pwr_q == ST_WAKING))
    else $error("select low did not start wake");
  // wake ends within the wake count
  a_wake_bound: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(pwr_q == ST_WAKING) |-> ##[1:400] awake)
    else $error("wake did not finish in time");
  // no load lands while the stable select copy is low
  a_tx_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    !selStable_q |=> $stable(txBuf_q))
    else $error("transmit buffer changed while selected");
  // data out released while deselected
  a_miso_release: assert property (@(posedge sys_clk)
    selectN |-> !misoOe)
    else $error("data out driven while deselected");
  // reset low gives programming mode one edge later
  a_prog_mode: assert property (@(posedge sys_clk)
    !resetn |=> progMode)
    else $error("programming mode missing under reset");
  // power states never overlap
  a_awake_exclusive: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(sleeping && awake))
    else $error("asleep and awake at once");
  // the full sleep delay of idle time precedes every sleep entry
  a_idle_before_sleep: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(sleeping) |-> (idleRun_q >= (CNT_W + 1)'(SLEEP_CYCLES)))
    else $error("sleep entered before the idle delay ran out");
  // waking lasts exactly the wake count
  a_wake_full: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pwr_q == ST_WAKING && pwr_d == ST_ACTIVE) |-> (wakeRun_q == (CNT_W + 1)'(WAKE_CYCLES - 1)))
    else $error("wake finished at the wrong count");
  // a wake starts only after select was seen low
  a_wake_only_selected: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(pwr_q == ST_WAKING) |-> (selRun_q != '0))
    else $error("wake started without select low");
  // tag work at the deciding edge forbids sleep
  a_busy_no_sleep: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(sleeping) |-> !$past(tagBusy))
    else $error("sleep entered with tag work pending");
  // select high at the deciding edge
  a_sleep_deselected: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(sleeping) |-> $past(selStable_q))
    else $error("sleep entered while selected");
  // with select still high, sleep holds
  a_sleep_holds: assert property (@(posedge sys_clk) disable iff (!resetn)
    (sleeping && selStable_q) |=> sleeping)
    else $error("sleep left without select low");
  // active never jumps straight to sleep
  a_no_direct_sleep: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pwr_q == ST_ACTIVE) |=> (pwr_q != ST_SLEEP))
    else $error("sleep entered without the delay");
  // a wake once started is not turned back into sleep
  a_wake_no_abort: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pwr_q == ST_WAKING) |=> (pwr_q != ST_SLEEP))
    else $error("wake turned back into sleep");
  // loads refused while the select copy is low
  a_ready_deselected: assert property (@(posedge sys_clk) disable iff (!resetn)
    !selStable_q |-> !txLoadReady)
    else $error("load offered while selected");
  // no drive on data out while programming
  a_oe_reset: assert property (@(posedge sys_clk)
    !resetn |-> !misoOe)
    else $error("data out driven in programming mode");
  // programming mode drops one edge after reset is released
  a_prog_clear: assert property (@(posedge sys_clk)
    $past(resetn) |-> !progMode)
    else $error("programming mode held after reset");
endmodule

/* File: bench/host_model.sv */
// host side serial master model for the select and sleep bench
`timescale 1ns/1ps
module host_model (
  // link pins
  output logic spiClk,
  output logic selectN,
  input wire logic misoOut,
  input wire logic misoOe
);
  // link clock idles low, select idles high
  initial begin
    spiClk = 1'b0;
    selectN = 1'b1;
  end
  // one whole byte per frame, select low only while it lasts
  task automatic frame(output logic [7:0] rx);
    selectN = 1'b0;
    #23000;
    for (int i = 7; i >= 0; i--) begin
      #15 spiClk = 1'b1;
      rx[i] = misoOe ? misoOut : 1'bx;
      #15 spiClk = 1'b0;
    end
    #15 selectN = 1'b1;
  endtask
endmodule

/* File: bench/tb.sv */
// bench for the select and sleep control block
`timescale 1ns/1ps
module tb;
  logic sys_clk, resetn, tagBusy, txLoadValid, txLoadReady, sleeping, awake, progMode;
  logic spiClk, selectN, misoOut, misoOe;
  logic [7:0] txLoadData, rx;
  int failures, checked, cyc;
  spi_select_sleep_control i_spi_select_sleep_control (.sys_clk(sys_clk), .resetn(resetn),
    .tagBusy(tagBusy), .txLoadValid(txLoadValid), .txLoadData(txLoadData),
    .txLoadReady(txLoadReady), .sleeping(sleeping), .awake(awake), .progMode(progMode),
    .spiClk(spiClk), .selectN(selectN), .misoOut(misoOut), .misoOe(misoOe));
  host_model i_host_model (.spiClk(spiClk), .selectN(selectN), .misoOut(misoOut),
    .misoOe(misoOe));
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wn(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // hang guard, well above the roughly 1800 cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  // load while deselected, then sleep after the select-high delay
  task automatic t_sleep();
    txLoadValid = 1'b1;
    txLoadData = 8'hA5;
    wn(6);
    check("ready", 8'(txLoadReady), 8'h01);
    txLoadValid = 1'b0;
    wn(380);
    check("early sleep", 8'(sleeping), 8'h00);
    wn(40);
    check("sleeping", 8'(sleeping), 8'h01);
    check("oe idle", 8'(misoOe), 8'h00);
  endtask
  // frame wakes the port, loads refused while selected
  task automatic t_wake();
    fork
      i_host_model.frame(rx);
      begin
        wn(10);
        check("ready sel", 8'(txLoadReady), 8'h00);
        tagBusy = 1'b1;
        wn(405);
        check("awake", 8'(awake), 8'h01);
      end
    join
    check("miso byte", rx, 8'hA5);
  endtask
  // pending tag work keeps the port awake
  task automatic t_busy();
    wn(450);
    check("busy awake", 8'(sleeping), 8'h00);
    tagBusy = 1'b0;
    wn(420);
    check("idle sleep", 8'(sleeping), 8'h01);
  endtask
  task automatic t_prog();
    resetn = 1'b0;
    wn(3);
    check("prog", 8'(progMode), 8'h01);
    check("oe prog", 8'(misoOe), 8'h00);
  endtask
  initial begin
    resetn = 1'b0;
    tagBusy = 1'b0;
    txLoadValid = 1'b0;
    txLoadData = 8'h00;
    wn(8);
    check("prog rst", 8'(progMode), 8'h01);
    resetn = 1'b1;
    t_sleep();
    t_wake();
    t_busy();
    t_prog();
    finish_test();
  end
endmodule
